// file: bench/smr_plant_model.sv
// Plant side model: board inputs, relay feedback, fault code, shaft position
`timescale 1ns/1ns
module smr_plant_model (
    input  wire logic        i_clk,
    input  wire logic        i_step,
    input  wire logic        i_second,
    output logic      [15:0] o_din,
    output logic      [7:0]  o_relay,
    output logic      [7:0]  o_fault,
    output logic      [7:0]  o_turns,
    output logic      [7:0]  o_angle
);
    logic [15:0] din_r = 16'h0000;
    initial
    begin
        o_relay = 8'h00;
        o_fault = 8'h00;
        o_turns = 8'h00;
        o_angle = 8'h00;
    end
    // New plant state only on request, so reads see settled pins
    always @(posedge i_clk)
    begin
        if (i_step)
        begin
            din_r   <= 16'($urandom);
            o_relay <= 8'($urandom);
            o_fault <= 8'($urandom) | 8'h01;
            o_turns <= 8'($urandom);
            o_angle <= 8'($urandom);
        end
    end
    // Input three held active selects the second time set
    assign o_din = i_second ? (din_r | 16'h0004) : din_r;
endmodule

// file: bench/smr_top_asserts.sv
// Checker bound to the top of the speed ramp and status word block
`timescale 1ns/1ns
module smr_top_asserts
    import smr_pkg::*;
#(
    parameter int CYC_TENTH = 2
)
(
    input wire logic        I_CLK,
    input wire logic        I_RESET,
    input wire logic [7:0]  I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic [15:0] I_SPEED_CMD,
    input wire logic [15:0] I_DIN,
    input wire logic [7:0]  I_RELAY,
    input wire logic [7:0]  I_FAULT_CODE,
    input wire logic        I_OVL_UP,
    input wire logic        I_OVL_DOWN,
    input wire logic [7:0]  I_TURNS,
    input wire logic [7:0]  I_ANGLE,
    input wire logic [15:0] O_SPEED_REF,
    input wire logic        O_RAMPING,
    input wire logic        O_OVERLOAD_FAULT,
    input wire logic        O_IRQ
);
    // Read strobe at one address
    sequence s_rd_at(logic [7:0] a);
        I_RD && (I_ADDR == a);
    endsequence
    // Two cycles inside a timed ramp
    sequence s_ramp_run;
        O_RAMPING ##1 O_RAMPING;
    endsequence

    // Reset clears every output, so no disable here
    a_reset_outputs: assert property (@(posedge I_CLK) I_RESET |=>
        (O_RDATA == 32'h0 && O_SPEED_REF == 16'h0 && !O_RAMPING && !O_IRQ))
        else $error("outputs not cleared by reset");
    a_rdata_idle: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !I_RD |=> O_RDATA == 32'h0) else $error("read data without read");
    a_unmapped_zero: assert property (@(posedge I_CLK) disable iff (I_RESET)
        s_rd_at(8'hFC) |=> O_RDATA == 32'h0) else $error("unmapped read not zero");
    // Stable pins make the registered copy equal the present value
    a_pos_pack: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (s_rd_at(OFS_POS) ##0 ($stable(I_TURNS) && $stable(I_ANGLE)))
        |=> O_RDATA == {16'h0000, $past(I_TURNS), $past(I_ANGLE)})
        else $error("position word packing wrong");
    a_fault_code: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (s_rd_at(OFS_FAULT) ##0 $stable(I_FAULT_CODE))
        |=> O_RDATA == {24'h0, $past(I_FAULT_CODE)})
        else $error("fault code read wrong");
    a_ovl_rise: assert property (@(posedge I_CLK) disable iff (I_RESET)
        $rose(O_OVERLOAD_FAULT) |-> $past(I_OVL_UP) && !$past(I_OVL_DOWN))
        else $error("overload fault without step up");
    a_ovl_fall: assert property (@(posedge I_CLK) disable iff (I_RESET)
        $fell(O_OVERLOAD_FAULT) |-> $past(I_OVL_DOWN) || $past(I_WR && I_ADDR == OFS_OVL))
        else $error("overload fault dropped without cause");
    // Wrap trick: a step of -1, 0 or +1 lands in 0..2
    a_ramp_step: assert property (@(posedge I_CLK) disable iff (I_RESET)
        s_ramp_run |-> (O_SPEED_REF - $past(O_SPEED_REF) + 16'h0001) <= 16'h0002)
        else $error("ramp moved more than one count");
endmodule

bind smr_top smr_top_asserts #(.CYC_TENTH(CYC_TENTH)) chk_u (.*);

// file: bench/tb_smr_top.sv
// Self-checking bench for the speed ramp and status word block
`timescale 1ns/1ns
module tb_smr_top;
    import smr_pkg::*;
    logic        I_CLK = 1'b0;
    logic        I_RESET = 1'b1;
    logic [7:0]  I_ADDR = 8'h00;
    logic [31:0] I_WDATA = 32'h0;
    logic        I_WR = 1'b0;
    logic        I_RD = 1'b0;
    logic [15:0] I_SPEED_CMD = 16'h0;
    logic        I_OVL_UP = 1'b0;
    logic        I_OVL_DOWN = 1'b0;
    logic [15:0] I_DIN;
    logic [7:0]  I_RELAY;
    logic [7:0]  I_FAULT_CODE;
    logic [7:0]  I_TURNS;
    logic [7:0]  I_ANGLE;
    logic [31:0] O_RDATA;
    logic [15:0] O_SPEED_REF;
    logic        O_RAMPING;
    logic        O_OVERLOAD_FAULT;
    logic        O_IRQ;
    logic        step = 1'b0;
    logic        second = 1'b0;
    logic        rd_q = 1'b0;
    logic [31:0] exp_q[$];
    int          err_total = 0;
    int          num_checks = 0;
    int          n;

    always #2 I_CLK = ~I_CLK;

    smr_top #(.CYC_TENTH(2)) dut_u (.*);
    smr_plant_model plant_u (.i_clk(I_CLK), .i_step(step), .i_second(second),
        .o_din(I_DIN), .o_relay(I_RELAY), .o_fault(I_FAULT_CODE),
        .o_turns(I_TURNS), .o_angle(I_ANGLE));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    // Expected value noted before the strobe goes out
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge I_CLK);
        exp_q.push_back(e);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
    endtask
    task tick(input int c);
        repeat (c) @(posedge I_CLK);
    endtask
    // Ramp to cmd and require the duration in lo..hi cycles
    task ramp(input logic [15:0] cmd, input int lo, input int hi);
        n = 0;
        @(posedge I_CLK);
        I_SPEED_CMD <= cmd;
        do
        begin
            @(posedge I_CLK);
            n++;
        end while ((O_SPEED_REF !== cmd || O_RAMPING !== 1'b0) && n < 300);
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int k = 0; k < 16; k++)
            rev16[k] = v[15 - k];
    endfunction

    // Read data stands only in the cycle after the strobe
    always @(posedge I_CLK)
    begin
        if (rd_q)
            chk(O_RDATA, exp_q.pop_front());
        rd_q <= I_RD;
    end

    // Generous span: whole run is a few thousand cycles
    initial
    begin
        #80000;
        err_total++;
        test_done();
    end

    initial
    begin
        void'($urandom(23280));
        tick(2);
        I_RESET <= 1'b0;
        rd(OFS_ACCEL1, 32'h3E8);
        rd(OFS_DECEL1, 32'h708);
        rd(OFS_ACCEL2, 32'h3E8);
        rd(OFS_DECEL2, 32'h708);
        rd(OFS_SCURVE, 32'h0);
        rd(8'hFC, 32'h0);
        wr(OFS_ACCEL1, 32'hFFFF);
        rd(OFS_ACCEL1, 32'h2706);
        wr(OFS_SCURVE, 32'hFFFF);
        rd(OFS_SCURVE, 32'h3E8);
        wr(OFS_MAXREF, 32'h10);
        wr(OFS_DIN, 32'hFFFF);
        // Random plant states; sync delay is four edges
        repeat (4)
        begin
            @(posedge I_CLK);
            step <= 1'b1;
            @(posedge I_CLK);
            step <= 1'b0;
            tick(6);
            rd(OFS_DIN, {16'h0, rev16(I_DIN)});
            rd(OFS_RELAY, {16'h0, rev16({8'h00, I_RELAY})} >> 8);
            rd(OFS_FAULT, {24'h0, I_FAULT_CODE});
            rd(OFS_POS, {16'h0, I_TURNS, I_ANGLE});
        end
        wr(OFS_ACCEL1, 32'h0);
        wr(OFS_SCURVE, 32'h0);
        ramp(16'h000A, 1, 3);
        wr(OFS_DECEL1, 32'h0);
        ramp(16'h0000, 1, 3);
        wr(OFS_ACCEL1, 32'hA);
        ramp(16'h0010, 19, 25);
        wr(OFS_DECEL1, 32'hA);
        wr(OFS_SCURVE, 32'h3E8);
        ramp(16'h0000, 24, 80);
        second <= 1'b1;
        wr(OFS_INSEL, 32'h3);
        wr(OFS_ACCEL2, 32'h14);
        wr(OFS_SCURVE, 32'h0);
        ramp(16'h0010, 39, 45);
        rd(OFS_SPEED, 32'h0002_0010);
        wr(OFS_DECEL2, 32'h14);
        wr(OFS_SCURVE, 32'h3E8);
        ramp(16'h0000, 44, 160);
        second <= 1'b0;
        rd(OFS_IRQ_STAT, 32'h5);
        wr(OFS_IRQ_MASK, 32'h2);
        wr(OFS_OVL, 32'h0);
        // 999 steps of 0.1 percent stay below full scale
        repeat (999)
        begin
            @(posedge I_CLK);
            I_OVL_UP <= 1'b1;
            @(posedge I_CLK);
            I_OVL_UP <= 1'b0;
        end
        tick(2);
        chk({31'h0, O_OVERLOAD_FAULT}, 32'h0);
        chk({31'h0, O_IRQ}, 32'h0);
        @(posedge I_CLK);
        I_OVL_UP <= 1'b1;
        @(posedge I_CLK);
        I_OVL_UP <= 1'b0;
        tick(2);
        chk({31'h0, O_OVERLOAD_FAULT}, 32'h1);
        chk({31'h0, O_IRQ}, 32'h1);
        rd(OFS_OVL, 32'h3E8);
        rd(OFS_IRQ_STAT, 32'h2);
        tick(2);
        chk({31'h0, O_IRQ}, 32'h0);
        @(posedge I_CLK);
        I_OVL_DOWN <= 1'b1;
        @(posedge I_CLK);
        I_OVL_DOWN <= 1'b0;
        tick(2);
        chk({31'h0, O_OVERLOAD_FAULT}, 32'h0);
        test_done();
    end
endmodule

// file: rtl/smr_io_if.sv
// Status path between the top and its input and overload helpers
`timescale 1ns/1ns
interface smr_io_if;
    logic [15:0] din_raw;
    logic [15:0] din_word;
    logic [7:0]  relay_raw;
    logic [7:0]  relay_word;
    logic        ovl_up;
    logic        ovl_down;
    logic        ovl_clear;
    logic        ovl_fault;
    logic [9:0]  ovl_level;

    modport top  (output din_raw, relay_raw, ovl_up, ovl_down, ovl_clear,
                  input din_word, relay_word, ovl_level, ovl_fault);
    modport pack (input din_raw, relay_raw, output din_word, relay_word);
    modport ovl  (input ovl_up, ovl_down, ovl_clear, output ovl_level, ovl_fault);
endinterface

// file: rtl/smr_overload.sv
// Overload accumulator in 0.1 percent steps with full-scale fault
`timescale 1ns/1ns
module smr_overload
    import smr_pkg::*;
(
    input  wire logic I_CLK,
    input  wire logic I_RESET,
    smr_io_if.ovl     io
);
    typedef struct packed {
        logic [9:0] level;
    } smr_ovl_t;

    smr_ovl_t s;
    smr_ovl_t next_s;

    // Saturates at full scale; clear beats both steps
    always_comb
    begin
        next_s = s;
        if (io.ovl_clear)
            next_s.level = '0;
        else if (io.ovl_up && !io.ovl_down && s.level < OVL_FULL)
            next_s.level = s.level + 10'h001; // R8
        else if (io.ovl_down && !io.ovl_up && s.level != '0)
            next_s.level = s.level - 10'h001;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
            s <= '0;
        else
            s <= next_s;
    end

    assign io.ovl_level = s.level;
    assign io.ovl_fault = (s.level >= OVL_FULL); // R8
endmodule

// file: rtl/smr_pack.sv
// Input and relay synchronisers and the mirrored status words
`timescale 1ns/1ns
module smr_pack
    import smr_pkg::*;
(
    input  wire logic I_CLK,
    input  wire logic I_RESET,
    smr_io_if.pack    io
);
    typedef struct packed {
        logic [23:0] s1;
        logic [23:0] s2;
        logic [23:0] s3;
        logic [23:0] stable;
    } smr_pack_t;

    smr_pack_t s;
    smr_pack_t next_s;

    // Stable bit follows only where stages two and three agree
    always_comb
    begin
        next_s        = s;
        next_s.s1     = {io.relay_raw, io.din_raw};
        next_s.s2     = s.s1;
        next_s.s3     = s.s2;
        next_s.stable = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.stable);
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
            s <= '0;
        else
            s <= next_s;
    end

    // Input n lands on bit 16-n, relay n on bit 8-n; active reads one
    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_din
            assign io.din_word[15 - i] = s.stable[i]; // R11 R14
            if (i < 8)
            begin : g_rel
                assign io.relay_word[7 - i] = s.stable[16 + i]; // R12 R14
            end
        end
    endgenerate
endmodule

// file: rtl/smr_pkg.sv
// Shared constants for the speed ramp and status word block
package smr_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_ACCEL1   = 8'h00;
    localparam logic [7:0] OFS_DECEL1   = 8'h04;
    localparam logic [7:0] OFS_ACCEL2   = 8'h08;
    localparam logic [7:0] OFS_DECEL2   = 8'h0C;
    localparam logic [7:0] OFS_SCURVE   = 8'h10;
    localparam logic [7:0] OFS_MAXREF   = 8'h14;
    localparam logic [7:0] OFS_INSEL    = 8'h18;
    localparam logic [7:0] OFS_SPEED    = 8'h1C;
    localparam logic [7:0] OFS_DIN      = 8'h20;
    localparam logic [7:0] OFS_RELAY    = 8'h24;
    localparam logic [7:0] OFS_FAULT    = 8'h28;
    localparam logic [7:0] OFS_OVL      = 8'h2C;
    localparam logic [7:0] OFS_POS      = 8'h30;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h38;

    // Reset values and limits, times in 0.1 s, fraction in 0.1 %
    localparam logic [15:0] ACCEL_RST   = 16'h03E8;
    localparam logic [15:0] DECEL_RST   = 16'h0708;
    localparam logic [15:0] TIME_MAX    = 16'h2706;
    localparam logic [15:0] SCURVE_MAX  = 16'h03E8;
    localparam logic [15:0] MAXREF_RST  = 16'h0E10;
    localparam logic [3:0]  INSEL_LO    = 4'h3;
    localparam logic [3:0]  INSEL_HI    = 4'hA;

    // Field positions
    localparam int SPD_RAMPING = 16;
    localparam int SPD_SECOND  = 17;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_OVL     = 1;
    localparam int IRQ_FAULT   = 2;

    // Overload full scale in 0.1 % steps
    localparam logic [9:0]  OVL_FULL   = 10'h3E8;

    // S-curve rate levels and level pacing numerator (2000 * 64)
    localparam logic [6:0]  LVL_FULL   = 7'h40;
    localparam logic [47:0] LVL_STEP   = 48'h0000_0001_F400;

    // Time base
    localparam int TENTH_S_NS    = 32'h05F5_E100;
    localparam int CLK_PERIOD_NS = 32'h0000_0004;
    localparam int CYC_PER_TENTH = TENTH_S_NS / CLK_PERIOD_NS;

endpackage

// file: rtl/smr_top.sv
// Speed reference ramp with register port and drive status words
`timescale 1ns/1ns

// Behaviour
// R1 - Zero selected ramp time makes the output jump straight to the command.
// R2 - Linear ramp covers zero to maximum reference in the set time, 0 to 999 s.
// R3 - Second time set is used while the chosen input three to ten is active.
// R4 - S fraction in percent sets the curved share of the ramp time.
// R5 - S fraction applies to whichever time set is currently selected.
// R6 - S fraction of zero gives a purely linear ramp.
// R7 - Reset gives accel 100.0 s, decel 180.0 s, S fraction zero.
// R8 - Overload builds in 0.1 % steps, fault raised at 100 %.
// R9 - Position word: turns in upper byte, angle in lower byte.
// R10 - Angle byte spans 0 to 360 degrees, about 1.4 degrees a count.
// R11 - Input word mirrored: input sixteen at bit 0, input one at bit 15.
// R12 - Relay word mirrored: relay eight at bit 0, ready relay at bit 7.
// R13 - A readable field holds the present fault code.
// R14 - Active signals read as one, inactive as zero.
module smr_top
    import smr_pkg::*;
#(
    parameter int CYC_TENTH = CYC_PER_TENTH
)
(
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    input  wire logic [15:0] I_SPEED_CMD,
    input  wire logic [15:0] I_DIN,
    input  wire logic [7:0]  I_RELAY,
    input  wire logic [7:0]  I_FAULT_CODE,
    input  wire logic        I_OVL_UP,
    input  wire logic        I_OVL_DOWN,
    input  wire logic [7:0]  I_TURNS,
    input  wire logic [7:0]  I_ANGLE,
    output logic      [15:0] O_SPEED_REF,
    output logic             O_RAMPING,
    output logic             O_OVERLOAD_FAULT,
    output logic             O_IRQ
);

    // Ramp, register and status state in one record; the helpers keep their own
    typedef struct packed {
        // Programmed settings
        logic [15:0] accel1;
        logic [15:0] decel1;
        logic [15:0] accel2;
        logic [15:0] decel2;
        logic [15:0] scurve;
        logic [15:0] maxref;
        logic [3:0]  insel;
        // Ramp engine
        logic [15:0] ref_out;
        logic [47:0] acc;
        logic [47:0] lvl_acc;
        logic [6:0]  lvl;
        logic [15:0] rise_dist;
        logic        falling;
        logic        ramping;
        logic        up;
        // Bus and status
        logic [31:0] rdata;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic [7:0]  fault_prev;
        logic        ovl_prev;
    } smr_state_t;

    localparam smr_state_t ST_RESET = '{
        accel1:  ACCEL_RST,
        decel1:  DECEL_RST,
        accel2:  ACCEL_RST,
        decel2:  DECEL_RST,
        scurve:  16'h0000,
        maxref:  MAXREF_RST,
        default: '0
    };

    smr_state_t s;
    smr_state_t next_s;

    smr_io_if io ();

    // Set selection, goal and direction
    logic        sel2;
    logic [4:0]  sel_bit;
    logic [15:0] target;
    logic        up_dir;
    logic [15:0] t_sel;
    logic [15:0] remaining;
    logic        fall_now;
    logic        at_target;

    // Rate arithmetic, wide enough for 9990 tenths at the full clock
    logic [47:0] denom;
    logic [47:0] s_thr;
    logic [47:0] inc;
    logic [47:0] sum;
    logic [47:0] lsum;

    // Status helpers
    logic        rd_stat;
    logic [2:0]  evt;

    // Write values beyond the range are held at the limit
    function automatic logic [15:0] smr_clamp(input logic [15:0] v,
                                              input logic [15:0] lim);
        logic [15:0] r;
        r = (v > lim) ? lim : v;
        return r;
    endfunction

    // Helpers that hold the status inputs
    smr_pack u_pack
    (
        .I_CLK   (I_CLK),
        .I_RESET (I_RESET),
        .io      (io)
    );

    smr_overload u_ovl
    (
        .I_CLK   (I_CLK),
        .I_RESET (I_RESET),
        .io      (io)
    );

    // Pins into the synchronisers, overload steps from same-clock logic
    assign io.din_raw   = I_DIN;
    assign io.relay_raw = I_RELAY;
    assign io.ovl_up    = I_OVL_UP;
    assign io.ovl_down  = I_OVL_DOWN;
    assign io.ovl_clear = I_WR && (I_ADDR == OFS_OVL);

    // Second ramp input: input n sits on mirrored bit 16-n
    // Codes outside three to ten leave the first set in charge
    always_comb
    begin
        sel_bit = 5'h10 - {1'b0, s.insel};
        sel2    = 1'b0;
        if (s.insel >= INSEL_LO && s.insel <= INSEL_HI)
            sel2 = io.din_word[sel_bit[3:0]]; // R3
    end

    // Ramp goal, direction and the time that governs it
    always_comb
    begin
        target    = (I_SPEED_CMD > s.maxref) ? s.maxref : I_SPEED_CMD;
        at_target = (s.ref_out == target);
        up_dir    = (target > s.ref_out);
        if (up_dir)
            t_sel = sel2 ? s.accel2 : s.accel1; // R3
        else
            t_sel = sel2 ? s.decel2 : s.decel1; // R3
        remaining = up_dir ? (target - s.ref_out) : (s.ref_out - target);
    end

    // Rate accumulator: maxref counts spread over t_sel tenths of a second
    // The curve level moves at most one step per clock, so very short ramp
    // times stretch the curved part; at real time scales this never binds
    always_comb
    begin
        denom = 48'(t_sel) * 48'(CYC_TENTH); // R2
        s_thr = 48'(s.scurve[9:0]) * denom; // R5
        if (s.scurve == 16'h0000)
        begin
            inc = 48'(s.maxref); // R6
        end
        else
        begin
            inc = 48'(({32'h0000_0000, s.maxref} * 48'(s.lvl)) >> 6); // R4
            // Small reference scales would round low levels to no motion
            if (inc == 48'h0000_0000_0000)
                inc = 48'h0000_0000_0001;
        end
        sum  = s.acc + inc;
        lsum = s.lvl_acc + LVL_STEP;
        fall_now = s.falling || (remaining <= s.rise_dist);
    end

    // Events for the sticky status word
    // Fault compare uses last cycle's code, so each change counts once
    always_comb
    begin
        evt            = '0;
        evt[IRQ_DONE]  = s.ramping && at_target;
        evt[IRQ_OVL]   = io.ovl_fault && !s.ovl_prev;
        evt[IRQ_FAULT] = (I_FAULT_CODE != s.fault_prev);
        rd_stat        = I_RD && (I_ADDR == OFS_IRQ_STAT);
    end

    // Next state: ramp engine, register writes and reads
    always_comb
    begin
        next_s            = s;
        next_s.rdata      = '0;
        next_s.fault_prev = I_FAULT_CODE;
        next_s.ovl_prev   = io.ovl_fault;
        // A new event wins over the clear by read
        next_s.stat       = (rd_stat ? 3'h0 : s.stat) | evt;

        // Ramp engine
        if (at_target)
        begin
            // Goal reached: park the profile so the next move starts from rest
            next_s.ramping   = 1'b0;
            next_s.acc       = '0;
            next_s.lvl_acc   = '0;
            next_s.lvl       = '0;
            next_s.rise_dist = '0;
            next_s.falling   = 1'b0;
        end
        else if (t_sel == 16'h0000)
        begin
            // No ramp: step the reference straight to the goal
            next_s.ref_out = target; // R1
            next_s.ramping = 1'b0;
        end
        else if (!s.ramping || s.up != up_dir)
        begin
            // Fresh ramp or reversal restarts the profile from rest
            next_s.ramping   = 1'b1;
            next_s.up        = up_dir;
            next_s.acc       = '0;
            next_s.lvl_acc   = '0;
            next_s.lvl       = '0;
            next_s.rise_dist = '0;
            next_s.falling   = 1'b0;
        end
        else
        begin
            // One count whenever the accumulator passes the span
            if (sum >= denom)
            begin
                next_s.acc = sum - denom; // R2
                if (s.up)
                    next_s.ref_out = s.ref_out + 16'h0001;
                else
                    next_s.ref_out = s.ref_out - 16'h0001;
                if (s.scurve != 16'h0000 && !fall_now && s.lvl < LVL_FULL)
                    next_s.rise_dist = s.rise_dist + 16'h0001;
            end
            else
            begin
                next_s.acc = sum;
            end

            // Curve: rate climbs over half the curved time, falls over the rest
            if (s.scurve != 16'h0000)
            begin
                next_s.falling = fall_now; // R4
                if (fall_now && s.lvl == 7'h00)
                begin
                    // Never let the rate die before the goal
                    next_s.lvl = 7'h01;
                end
                else if ((!fall_now && s.lvl < LVL_FULL) ||
                         (fall_now && s.lvl > 7'h01))
                begin
                    if (lsum >= s_thr)
                    begin
                        next_s.lvl_acc = lsum - s_thr; // R4
                        if (fall_now)
                            next_s.lvl = s.lvl - 7'h01;
                        else
                            next_s.lvl = s.lvl + 7'h01;
                    end
                    else
                    begin
                        next_s.lvl_acc = lsum;
                    end
                end
            end
        end

        // Register writes
        // Read-only and unmapped offsets fall through, but a write to OFS_OVL still clears the overload level
        if (I_WR)
        begin
            case (I_ADDR)
                OFS_ACCEL1:   next_s.accel1 = smr_clamp(I_WDATA[15:0], TIME_MAX); // R2
                OFS_DECEL1:   next_s.decel1 = smr_clamp(I_WDATA[15:0], TIME_MAX); // R2
                OFS_ACCEL2:   next_s.accel2 = smr_clamp(I_WDATA[15:0], TIME_MAX); // R2
                OFS_DECEL2:   next_s.decel2 = smr_clamp(I_WDATA[15:0], TIME_MAX); // R2
                OFS_SCURVE:   next_s.scurve = smr_clamp(I_WDATA[15:0], SCURVE_MAX); // R4
                OFS_MAXREF:   next_s.maxref = I_WDATA[15:0];
                OFS_INSEL:    next_s.insel = I_WDATA[3:0];
                OFS_IRQ_MASK: next_s.mask = I_WDATA[2:0];
                default:      next_s.mask = s.mask;
            endcase
        end

        // Register reads, data shown in the following cycle only
        if (I_RD)
        begin
            case (I_ADDR)
                OFS_ACCEL1:   next_s.rdata = {16'h0000, s.accel1};
                OFS_DECEL1:   next_s.rdata = {16'h0000, s.decel1};
                OFS_ACCEL2:   next_s.rdata = {16'h0000, s.accel2};
                OFS_DECEL2:   next_s.rdata = {16'h0000, s.decel2};
                OFS_SCURVE:   next_s.rdata = {16'h0000, s.scurve};
                OFS_MAXREF:   next_s.rdata = {16'h0000, s.maxref};
                OFS_INSEL:    next_s.rdata = {28'h000_0000, s.insel};
                OFS_SPEED:
                begin
                    next_s.rdata                = {16'h0000, s.ref_out};
                    next_s.rdata[SPD_RAMPING]   = s.ramping;
                    next_s.rdata[SPD_SECOND]    = sel2;
                end
                OFS_DIN:      next_s.rdata = {16'h0000, io.din_word}; // R11
                OFS_RELAY:    next_s.rdata = {24'h00_0000, io.relay_word}; // R12
                OFS_FAULT:    next_s.rdata = {24'h00_0000, s.fault_prev}; // R13
                OFS_OVL:      next_s.rdata = {22'h00_0000, io.ovl_level}; // R8
                OFS_POS:      next_s.rdata = {16'h0000, I_TURNS, I_ANGLE}; // R9 R10
                OFS_IRQ_STAT: next_s.rdata = {29'h0000_0000, s.stat};
                OFS_IRQ_MASK: next_s.rdata = {29'h0000_0000, s.mask};
                default:      next_s.rdata = '0;
            endcase
        end
    end

    // Synchronous reset loads the documented defaults
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
            s <= ST_RESET; // R7
        else
            s <= next_s;
    end

    // Outputs straight from state
    assign O_RDATA          = s.rdata;
    assign O_SPEED_REF      = s.ref_out;
    assign O_RAMPING        = s.ramping;
    assign O_OVERLOAD_FAULT = io.ovl_fault; // R8
    // Level interrupt; software drops it by reading the status word
    assign O_IRQ            = |(s.stat & s.mask);

endmodule
